//--- rtl/lddr_core.sv
// configuration port, per-device irq/dma selectors and function-local gating
`default_nettype none

//Contract
// - device base addresses decode from host address bits eleven down to zero; the code compares bits eleven to one (two-byte window).
// - oscillator config bit six adds a check that address bits fifteen-twelve are zero.
// - config port powers up at 0x02E or 0x04E by strap, relocatable later.
// - relocated config port lies in 0x0100-0x0FFE, even; data port at base plus one.
// - interrupt selector low four bits pick IRQ1-15; zero picks none; code two shared.
// - interrupt selector resets to 0x06 for device zero, 0x00 otherwise, all resets.
// - routed interrupts are active high except parallel port ECP/EPP; SMI is low.
// - interrupt active only with non-zero selector and function enable; floppy uses D3.
// - parallel interrupt needs control bit D4; ECP mode also needs service bit clear.
// - serial interrupt needs some enable bit D0-D3 and auxiliary output two set.
// - interrupt lines nobody selects stay disabled.
// - every selector interrupt number is deliverable on the serialized interrupt vector; the code drives the parallel irq_lines_q vector.
// - DMA selector low three bits: one to three pick channels, others pick none.
// - DMA selector resets to 0x02 for device zero, 0x04 for devices three, five.
// - DMA active only with selector one to three and the function's DMA enable.
// - DMA channels nobody selects stay disabled.
// - floppy interrupt and DMA off when its DMA enable is zero or powered down.
// - serial interrupt off when auxiliary output two is zero; UART2 DMA follows enable.
// - parallel DMA follows ECP DMA enable; interrupt forced on in 010, 011, 110.
// - local disables add to disabling by inactive device or invalid base.
// - standard and EPP parallel modes disable the interrupt when D4 is zero.
module lddr_core (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic config_port_strap,
    input wire lddr_pkg::lddr_io_req_t io_req,
    input wire lddr_pkg::lddr_fn_ctl_t fn_ctl,
    input wire logic [lddr_pkg::LDDR_LDN_COUNT-1:0] fn_irq_req,
    input wire logic [lddr_pkg::LDDR_LDN_COUNT-1:0] fn_drq,
    input wire logic smi_enable,
    input wire logic smi_req,
    output logic [7:0] io_rdata_q,
    output logic io_rd_ack_q,
    output logic [15:0] irq_lines_q,
    output logic [15:0] irq_low_pol_q,
    output logic [3:0] dma_req_q,
    output logic system_mgmt_interrupt_n_q,
    output logic [lddr_pkg::LDDR_LDN_COUNT-1:0] ld_hit_q,
    output logic [15:0] cfg_base_q
);
    import lddr_pkg::*;

    localparam int N = LDDR_LDN_COUNT;

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // low twelve bits always compared, top nibble only in full mode
    function automatic logic port_hit(input logic [15:0] addr,
                                      input logic [15:0] target,
                                      input logic full16);
        port_hit = (addr[11:0] == target[11:0])
            && (!full16 || (addr[15:12] == 4'h0));
    endfunction

    // relocation target must be even and inside the allowed window
    function automatic logic reloc_ok(input logic [15:0] cand);
        reloc_ok = !cand[0] && (cand >= LDDR_RELOC_MIN)
            && (cand <= LDDR_RELOC_MAX);
    endfunction

    function automatic logic [3:0] irq_sel_default(input int i);
        irq_sel_default = (i == int'(LDDR_LDN_FLOPPY))
            ? LDDR_IRQ_SEL_RST_FLOPPY : LDDR_IRQ_SEL_NONE;
    endfunction

    function automatic logic [2:0] dma_sel_default(input int i);
        dma_sel_default = (i == int'(LDDR_LDN_FLOPPY))
            ? LDDR_DMA_SEL_RST_FLOPPY : LDDR_DMA_SEL_RST_OTHER;
    endfunction

    // reset image of the whole state; constants only
    function automatic lddr_state_t state_reset();
        lddr_state_t r;
        r = '0;
        r.osc = LDDR_OSC_RST;
        r.cfg_base = LDDR_CFG_BASE_STRAP_LO;
        r.smi_n = 1'b1;
        for (int i = 0; i < N; i++)
        begin
            r.irq_sel[i] = irq_sel_default(i);
            r.dma_sel[i] = dma_sel_default(i);
        end
        return r;
    endfunction

    // ****************************************************************
    // strap capture
    // ****************************************************************
    logic strap_level;
    logic strap_stable;

    lddr_sync u_strap_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(config_port_strap),
        .level(strap_level),
        .stable(strap_stable)
    );

    // ****************************************************************
    // function-local gates
    // ****************************************************************
    logic [N-1:0] gate_irq;
    logic [N-1:0] gate_dma;
    logic [N-1:0] low_pol;
    logic pp_forced_on;
    logic pp_ecp;

    // devices without a gate here stay off, so their lines stay idle
    always_comb
    begin
        gate_irq = '0;
        gate_dma = '0;
        low_pol = '0;
        pp_ecp = (fn_ctl.parport_mode == LDDR_PP_MODE_ECP);
        pp_forced_on = (fn_ctl.parport_mode == LDDR_PP_MODE_FIFO) || pp_ecp
            || (fn_ctl.parport_mode == LDDR_PP_MODE_TEST);
        gate_irq[LDDR_LDN_FLOPPY] = fn_ctl.floppy_dma_gate
            && !fn_ctl.floppy_powered_down;
        gate_dma[LDDR_LDN_FLOPPY] = fn_ctl.floppy_dma_gate
            && !fn_ctl.floppy_powered_down;
        gate_irq[LDDR_LDN_PARPORT] = (pp_forced_on || fn_ctl.parport_irq_gate)
            && !(pp_ecp && fn_ctl.ecp_service_pending);
        gate_dma[LDDR_LDN_PARPORT] = fn_ctl.ecp_dma_gate;
        low_pol[LDDR_LDN_PARPORT] = pp_ecp
            || (fn_ctl.parport_mode == LDDR_PP_MODE_EPP);
        gate_irq[LDDR_LDN_UART1] = (|fn_ctl.uart1_irq_enable_reg)
            && fn_ctl.uart1_modem_aux_output_two;
        gate_irq[LDDR_LDN_UART2] = (|fn_ctl.uart2_irq_enable_reg)
            && fn_ctl.uart2_modem_aux_output_two;
        gate_dma[LDDR_LDN_UART2] = fn_ctl.uart2_dma_gate;
    end

    // ****************************************************************
    // per-device routing
    // ****************************************************************
    lddr_state_t s_q;
    lddr_state_t s_d;
    logic [N-1:0][15:0] dev_irq;
    logic [N-1:0][15:0] dev_pol;
    logic [N-1:0][3:0] dev_dma;
    logic [N-1:0] dev_live;

    // inactive device or zero base blocks everything, on top of local gates
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            dev_live[i] = s_q.active[i] && (s_q.ld_base[i] != 16'h0000);
        end
    end

    for (genvar g = 0; g < N; g++)
    begin : g_route
        lddr_route u_route (
            .irq_sel(s_q.irq_sel[g]),
            .dma_sel(s_q.dma_sel[g]),
            .dev_live(dev_live[g]),
            .irq_gate(gate_irq[g]),
            .dma_gate(gate_dma[g]),
            .irq_req(fn_irq_req[g]),
            .drq(fn_drq[g]),
            .low_pol(low_pol[g]),
            .irq_vec(dev_irq[g]),
            .irq_pol_vec(dev_pol[g]),
            .dma_vec(dev_dma[g])
        );
    end

    logic [15:0] irq_all;
    logic [15:0] pol_all;
    logic [3:0] dma_all;

    // merge every device; unused lines remain zero
    always_comb
    begin
        irq_all = '0;
        pol_all = '0;
        dma_all = '0;
        for (int i = 0; i < N; i++)
        begin
            irq_all = irq_all | dev_irq[i];
            pol_all = pol_all | dev_pol[i];
            dma_all = dma_all | dev_dma[i];
        end
    end

    // ****************************************************************
    // register read mux
    // ****************************************************************
    logic ldn_ok;
    logic [7:0] reg_rd;

    always_comb
    begin
        ldn_ok = (s_q.ldn < 4'(N));
        reg_rd = 8'h00;
        unique case (s_q.index)
            LDDR_IDX_LDN: reg_rd = {4'h0, s_q.ldn};
            LDDR_IDX_OSC: reg_rd = s_q.osc;
            LDDR_IDX_RELOC_LO: reg_rd = s_q.cfg_base[7:0];
            LDDR_IDX_RELOC_HI: reg_rd = s_q.cfg_base[15:8];
            LDDR_IDX_ACTIVE: reg_rd = {7'h00, ldn_ok && s_q.active[s_q.ldn]};
            LDDR_IDX_BASE_HI: reg_rd = ldn_ok ? s_q.ld_base[s_q.ldn][15:8] : 8'h00;
            LDDR_IDX_BASE_LO: reg_rd = ldn_ok ? s_q.ld_base[s_q.ldn][7:0] : 8'h00;
            LDDR_IDX_IRQ_SEL: reg_rd = ldn_ok ? {4'h0, s_q.irq_sel[s_q.ldn]} : 8'h00;
            LDDR_IDX_DMA_SEL: reg_rd = ldn_ok ? {5'h00, s_q.dma_sel[s_q.ldn]} : 8'h00;
            default: reg_rd = 8'h00;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    logic full16;
    logic idx_hit;
    logic data_hit;
    logic [15:0] reloc_cand;

    always_comb
    begin
        s_d = s_q;
        s_d.rd_ack = 1'b0;
        full16 = s_q.osc[LDDR_OSC_FULL_DECODE_BIT];
        idx_hit = port_hit(io_req.addr, s_q.cfg_base, full16);
        data_hit = port_hit(io_req.addr, s_q.cfg_base + 16'h0001, full16);
        reloc_cand = s_q.cfg_base;

        // strap sampled once after release, when the synchroniser settles
        if (!s_q.strap_done && strap_stable)
        begin
            s_d.cfg_base = strap_level ? LDDR_CFG_BASE_STRAP_HI
                : LDDR_CFG_BASE_STRAP_LO;
            s_d.strap_done = 1'b1;
        end

        // index port: entry key, exit key, or index byte while open
        if (io_req.wr && idx_hit)
        begin
            if (!s_q.cfg_mode)
            begin
                s_d.cfg_mode = (io_req.wdata == LDDR_KEY_ENTER);
            end
            else if (io_req.wdata == LDDR_KEY_EXIT)
            begin
                s_d.cfg_mode = 1'b0;
            end
            else
            begin
                s_d.index = io_req.wdata;
            end
        end

        // data port writes; out-of-range device numbers write no per-device register
        if (io_req.wr && data_hit && s_q.cfg_mode)
        begin
            unique case (s_q.index)
                LDDR_IDX_LDN: s_d.ldn = io_req.wdata[3:0];
                LDDR_IDX_OSC: s_d.osc = io_req.wdata;
                LDDR_IDX_RELOC_LO:
                begin
                    reloc_cand = {s_q.cfg_base[15:8], io_req.wdata};
                    if (reloc_ok(reloc_cand))
                    begin
                        s_d.cfg_base = reloc_cand;
                    end
                end
                LDDR_IDX_RELOC_HI:
                begin
                    reloc_cand = {io_req.wdata, s_q.cfg_base[7:0]};
                    if (reloc_ok(reloc_cand))
                    begin
                        s_d.cfg_base = reloc_cand;
                    end
                end
                LDDR_IDX_ACTIVE:
                begin
                    if (ldn_ok)
                    begin
                        s_d.active[s_q.ldn] = io_req.wdata[0];
                    end
                end
                LDDR_IDX_BASE_HI:
                begin
                    if (ldn_ok)
                    begin
                        s_d.ld_base[s_q.ldn][15:8] = io_req.wdata;
                    end
                end
                LDDR_IDX_BASE_LO:
                begin
                    if (ldn_ok)
                    begin
                        s_d.ld_base[s_q.ldn][7:0] = io_req.wdata;
                    end
                end
                LDDR_IDX_IRQ_SEL:
                begin
                    if (ldn_ok)
                    begin
                        s_d.irq_sel[s_q.ldn] = io_req.wdata[3:0];
                    end
                end
                LDDR_IDX_DMA_SEL:
                begin
                    if (ldn_ok)
                    begin
                        s_d.dma_sel[s_q.ldn] = io_req.wdata[2:0];
                    end
                end
                default: ;
            endcase
        end

        // reads answer only while the configuration port is open
        if (io_req.rd && s_q.cfg_mode && (idx_hit || data_hit))
        begin
            s_d.rdata = idx_hit ? s_q.index : reg_rd;
            s_d.rd_ack = 1'b1;
        end

        // soft reset returns only the selectors to their defaults
        if (soft_reset)
        begin
            for (int i = 0; i < N; i++)
            begin
                s_d.irq_sel[i] = irq_sel_default(i);
                s_d.dma_sel[i] = dma_sel_default(i);
            end
        end

        // device window hit: two-byte span on bits eleven to one
        for (int i = 0; i < N; i++)
        begin
            s_d.ld_hit[i] = (io_req.wr || io_req.rd) && dev_live[i]
                && port_hit({io_req.addr[15:1], 1'b0},
                            {s_q.ld_base[i][15:1], 1'b0}, full16);
        end

        // full vector is registered straight to the irq_lines output
        s_d.irq_lines = irq_all;
        s_d.irq_low_pol = pol_all;
        s_d.dma_req = dma_all;
        // code two is shared; keeping both apart is up to software
        s_d.smi_n = !(smi_enable && smi_req);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= state_reset();
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs, all straight from the state register
    // ****************************************************************
    assign io_rdata_q = s_q.rdata;
    assign io_rd_ack_q = s_q.rd_ack;
    assign irq_lines_q = s_q.irq_lines;
    assign irq_low_pol_q = s_q.irq_low_pol;
    assign dma_req_q = s_q.dma_req;
    assign system_mgmt_interrupt_n_q = s_q.smi_n;
    assign ld_hit_q = s_q.ld_hit;
    assign cfg_base_q = s_q.cfg_base;
endmodule // lddr_core

`default_nettype wire

//--- rtl/lddr_pkg.sv
// constants, carriers and state layout of the logical device irq/dma routing block
`default_nettype none

package lddr_pkg;

    // ****************************************************************
    // sizes and configuration register indices
    // ****************************************************************
    localparam int LDDR_LDN_COUNT = 12;
    localparam logic [7:0] LDDR_IDX_LDN = 8'h07;
    localparam logic [7:0] LDDR_IDX_OSC = 8'h24;
    localparam logic [7:0] LDDR_IDX_RELOC_LO = 8'h26;
    localparam logic [7:0] LDDR_IDX_RELOC_HI = 8'h27;
    localparam logic [7:0] LDDR_IDX_ACTIVE = 8'h30;
    localparam logic [7:0] LDDR_IDX_BASE_HI = 8'h60;
    localparam logic [7:0] LDDR_IDX_BASE_LO = 8'h61;
    localparam logic [7:0] LDDR_IDX_IRQ_SEL = 8'h70;
    localparam logic [7:0] LDDR_IDX_DMA_SEL = 8'h74;
    localparam logic [7:0] LDDR_KEY_ENTER = 8'h55;
    localparam logic [7:0] LDDR_KEY_EXIT = 8'hAA;
    localparam int LDDR_OSC_FULL_DECODE_BIT = 6;

    // ****************************************************************
    // configuration port location
    // ****************************************************************
    localparam logic [15:0] LDDR_CFG_BASE_STRAP_LO = 16'h002E;
    localparam logic [15:0] LDDR_CFG_BASE_STRAP_HI = 16'h004E;
    localparam logic [15:0] LDDR_RELOC_MIN = 16'h0100;
    localparam logic [15:0] LDDR_RELOC_MAX = 16'h0FFE;

    // ****************************************************************
    // logical device numbers, selector codes and reset values
    // ****************************************************************
    localparam logic [3:0] LDDR_LDN_FLOPPY = 4'h0;
    localparam logic [3:0] LDDR_LDN_PARPORT = 4'h3;
    localparam logic [3:0] LDDR_LDN_UART1 = 4'h4;
    localparam logic [3:0] LDDR_LDN_UART2 = 4'h5;
    localparam logic [3:0] LDDR_IRQ_SEL_NONE = 4'h0;
    localparam logic [3:0] LDDR_IRQ_SEL_RST_FLOPPY = 4'h6;
    localparam logic [2:0] LDDR_DMA_SEL_MIN = 3'h1;
    localparam logic [2:0] LDDR_DMA_SEL_MAX = 3'h3;
    localparam logic [2:0] LDDR_DMA_SEL_RST_FLOPPY = 3'h2;
    localparam logic [2:0] LDDR_DMA_SEL_RST_OTHER = 3'h4;
    localparam logic [7:0] LDDR_OSC_RST = 8'h00;

    // parallel port extended control modes
    localparam logic [2:0] LDDR_PP_MODE_FIFO = 3'b010;
    localparam logic [2:0] LDDR_PP_MODE_ECP = 3'b011;
    localparam logic [2:0] LDDR_PP_MODE_EPP = 3'b100;
    localparam logic [2:0] LDDR_PP_MODE_TEST = 3'b110;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } lddr_io_req_t;

    typedef struct packed {
        logic floppy_dma_gate;
        logic floppy_powered_down;
        logic parport_irq_gate;
        logic [2:0] parport_mode;
        logic ecp_service_pending;
        logic ecp_dma_gate;
        logic [3:0] uart1_irq_enable_reg;
        logic uart1_modem_aux_output_two;
        logic [3:0] uart2_irq_enable_reg;
        logic uart2_modem_aux_output_two;
        logic uart2_dma_gate;
    } lddr_fn_ctl_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [2:0] fill;
    } lddr_sync_t;

    typedef struct packed {
        logic cfg_mode;
        logic [7:0] index;
        logic [3:0] ldn;
        logic [7:0] osc;
        logic [15:0] cfg_base;
        logic strap_done;
        logic [7:0] rdata;
        logic rd_ack;
        logic [LDDR_LDN_COUNT-1:0] active;
        logic [LDDR_LDN_COUNT-1:0][15:0] ld_base;
        logic [LDDR_LDN_COUNT-1:0][3:0] irq_sel;
        logic [LDDR_LDN_COUNT-1:0][2:0] dma_sel;
        logic [15:0] irq_lines;
        logic [15:0] irq_low_pol;
        logic [3:0] dma_req;
        logic smi_n;
        logic [LDDR_LDN_COUNT-1:0] ld_hit;
    } lddr_state_t;

endpackage

`default_nettype wire

//--- rtl/lddr_sync.sv
// three-stage synchroniser for a pin level, with an agreement flag
`default_nettype none

module lddr_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic level,
    output logic stable
);
    import lddr_pkg::*;

    lddr_sync_t s_q;
    lddr_sync_t s_d;

    // first stage feeds only the second stage
    always_comb
    begin
        s_d.s1 = pin_in;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        s_d.fill = {s_q.fill[1:0], 1'b1};
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // reset zeros look settled, so wait for the pipe to fill
    assign level = s_q.s3;
    assign stable = s_q.fill[2] && (s_q.s2 == s_q.s3);
endmodule // lddr_sync

`default_nettype wire

//--- rtl/lddr_route.sv
// one logical device: selector codes and gates to one-hot irq/dma vectors
`default_nettype none

module lddr_route (
    input wire logic [3:0] irq_sel,
    input wire logic [2:0] dma_sel,
    input wire logic dev_live,
    input wire logic irq_gate,
    input wire logic dma_gate,
    input wire logic irq_req,
    input wire logic drq,
    input wire logic low_pol,
    output logic [15:0] irq_vec,
    output logic [15:0] irq_pol_vec,
    output logic [3:0] dma_vec
);
    import lddr_pkg::*;

    // unselected or gated lines stay at zero so sharers are undisturbed
    always_comb
    begin
        irq_vec = '0;
        irq_pol_vec = '0;
        dma_vec = '0;
        if (dev_live && irq_gate && (irq_sel != LDDR_IRQ_SEL_NONE))
        begin
            irq_vec[irq_sel] = low_pol ? ~irq_req : irq_req;
            irq_pol_vec[irq_sel] = low_pol;
        end
        if (dev_live && dma_gate && (dma_sel >= LDDR_DMA_SEL_MIN)
            && (dma_sel <= LDDR_DMA_SEL_MAX))
        begin
            dma_vec[dma_sel[1:0]] = drq;
        end
    end
endmodule // lddr_route

`default_nettype wire

//--- tb/lddr_assertions.sv
// port-level checks for the irq/dma routing core
`default_nettype none
module lddr_assertions
    import lddr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire lddr_pkg::lddr_io_req_t io_req,
    input wire lddr_pkg::lddr_fn_ctl_t fn_ctl,
    input wire logic [lddr_pkg::LDDR_LDN_COUNT-1:0] fn_irq_req,
    input wire logic [lddr_pkg::LDDR_LDN_COUNT-1:0] fn_drq,
    input wire logic smi_enable,
    input wire logic smi_req,
    input wire logic io_rd_ack_q,
    input wire logic [15:0] irq_lines_q,
    input wire logic [15:0] irq_low_pol_q,
    input wire logic [3:0] dma_req_q,
    input wire logic system_mgmt_interrupt_n_q,
    input wire logic [lddr_pkg::LDDR_LDN_COUNT-1:0] ld_hit_q,
    input wire logic [15:0] cfg_base_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // gates closed: outputs follow one edge later
    sequence s_dma_off;
        !fn_ctl.floppy_dma_gate && !fn_ctl.ecp_dma_gate && !fn_ctl.uart2_dma_gate;
    endsequence
    sequence s_irq_off;
        !fn_ctl.floppy_dma_gate && !fn_ctl.parport_irq_gate && fn_ctl.parport_mode == 3'b000
            && !fn_ctl.uart1_modem_aux_output_two && !fn_ctl.uart2_modem_aux_output_two;
    endsequence
    // no request now, no inverted line next
    sequence s_no_req;
        fn_irq_req == '0 ##1 irq_low_pol_q == '0;
    endsequence
    a_dma_gated: assert property (s_dma_off |=> dma_req_q == 4'h0)
        else $error("dma with gates closed");
    a_irq_gated: assert property (s_irq_off |=> irq_lines_q == 16'h0000)
        else $error("irq with gates closed");
    a_irq_idle: assert property (s_no_req |-> irq_lines_q == 16'h0000)
        else $error("irq line without request");
    a_dma_idle: assert property (fn_drq == '0 |=> dma_req_q == 4'h0)
        else $error("dma without request");
    a_chan_zero: assert property (dma_req_q[0] == 1'b0)
        else $error("dma channel zero driven");
    a_line_zero: assert property (irq_lines_q[0] == 1'b0)
        else $error("irq line zero driven");
    a_smi_low: assert property (system_mgmt_interrupt_n_q == !$past(smi_enable && smi_req))
        else $error("smi level wrong");
    a_rd_answer: assert property (io_rd_ack_q |-> $past(io_req.rd))
        else $error("read ack without read");
    a_cfg_legal: assert property (cfg_base_q inside {16'h002e, 16'h004e}
        || (cfg_base_q >= 16'h0100 && cfg_base_q <= 16'h0ffe && !cfg_base_q[0]))
        else $error("config port out of range");
    a_hit_cause: assert property (|ld_hit_q |-> $past(io_req.wr || io_req.rd))
        else $error("window hit without access");
endmodule // lddr_assertions

bind lddr_core lddr_assertions i_chk (.clk_sys, .rst_n, .io_req, .fn_ctl, .fn_irq_req,
    .fn_drq, .smi_enable, .smi_req, .io_rd_ack_q, .irq_lines_q, .irq_low_pol_q, .dma_req_q,
    .system_mgmt_interrupt_n_q, .ld_hit_q, .cfg_base_q);
`default_nettype wire

//--- tb/lddr_host_model.sv
// host model issuing configuration port cycles
`default_nettype none
module lddr_host_model
    import lddr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [7:0] io_rdata_q,
    input wire logic io_rd_ack_q,
    output var lddr_pkg::lddr_io_req_t io_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial io_req = '0;
    // released lines carry inverted values, never the stale ones
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        io_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk_sys);
        io_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
    // ack lands on the taking edge and is sampled at the next negedge
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_sys);
        io_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge clk_sys);
        ok = io_rd_ack_q;
        d = io_rdata_q;
        io_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
    endtask
endmodule // lddr_host_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the irq/dma routing core
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import lddr_pkg::*;
    logic clk_sys, rst_n, soft_reset, config_port_strap, smi_enable, smi_req, io_rd_ack_q;
    logic system_mgmt_interrupt_n_q, ok;
    lddr_io_req_t io_req;
    lddr_fn_ctl_t fn_ctl;
    logic [LDDR_LDN_COUNT-1:0] fn_irq_req, fn_drq, ld_hit_q;
    logic [15:0] irq_lines_q, irq_low_pol_q, cfg_base_q, cfg;
    logic [7:0] io_rdata_q, d;
    logic [3:0] dma_req_q;
    int errors = 0;
    int n_compared = 0;
    // {gate, powered down, irq req, drq} beside {irq6, dma2}
    logic [5:0] rows [4] = '{6'b101111, 6'b001100, 6'b111100, 6'b100000};
    lddr_core i_dut (.clk_sys, .rst_n, .soft_reset, .config_port_strap, .io_req, .fn_ctl,
        .fn_irq_req, .fn_drq, .smi_enable, .smi_req, .io_rdata_q, .io_rd_ack_q, .irq_lines_q,
        .irq_low_pol_q, .dma_req_q, .system_mgmt_interrupt_n_q, .ld_hit_q, .cfg_base_q);
    lddr_host_model i_host (.clk_sys, .io_rdata_q, .io_rd_ack_q, .io_req);
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic set(input logic [7:0] idx, input logic [7:0] v);
        i_host.wr(cfg, idx);
        i_host.wr(cfg + 16'h0001, v);
    endtask
    // read selected register, ack and data checked together
    task automatic get(input logic [7:0] idx, input logic [7:0] exp);
        i_host.wr(cfg, idx);
        i_host.rd(cfg + 16'h0001, d, ok);
        chk({7'h00, ok, d}, {8'h01, exp});
    endtask
    task automatic end_sim;
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard, about 3000 cycles
    initial
    begin
        #75000;
        errors++;
        end_sim();
    end
    initial
    begin
        {rst_n, soft_reset, config_port_strap, smi_req} = 4'h2;
        smi_enable = 1'b0;
        {fn_ctl, fn_irq_req, fn_drq} = '0;
        cfg = LDDR_CFG_BASE_STRAP_HI;
        repeat (3) @(negedge clk_sys);
        chk(cfg_base_q, 16'h002e);
        rst_n = 1'b1;
        smi_req = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(cfg_base_q, 16'h004e);
        i_host.wr(cfg, LDDR_KEY_ENTER);
        set(LDDR_IDX_LDN, 8'h03);
        get(LDDR_IDX_IRQ_SEL, 8'h00);
        get(LDDR_IDX_DMA_SEL, 8'h04);
        set(LDDR_IDX_LDN, 8'h00);
        get(LDDR_IDX_IRQ_SEL, 8'h06);
        get(LDDR_IDX_DMA_SEL, 8'h02);
        set(LDDR_IDX_ACTIVE, 8'h01);
        set(LDDR_IDX_BASE_HI, 8'h03);
        set(LDDR_IDX_BASE_LO, 8'hf0);
        foreach (rows[i])
        begin
            {fn_ctl.floppy_dma_gate, fn_ctl.floppy_powered_down, fn_irq_req[0], fn_drq[0]} =
                rows[i][5:2];
            repeat (2) @(negedge clk_sys);
            chk(irq_lines_q, 16'(rows[i][1]) << 6);
            chk(16'(dma_req_q), 16'(rows[i][0]) << 2);
        end
        {fn_irq_req[0], fn_drq[0]} = 2'b11;
        for (int k = 0; k < 16; k++)
        begin
            set(LDDR_IDX_IRQ_SEL, 8'(k));
            repeat (2) @(negedge clk_sys);
            chk(irq_lines_q, (k == 0) ? 16'h0000 : 16'h0001 << k);
        end
        for (int k = 0; k < 8; k++)
        begin
            set(LDDR_IDX_DMA_SEL, 8'(k));
            repeat (2) @(negedge clk_sys);
            chk(16'(dma_req_q), (k >= 1 && k <= 3) ? 16'h0001 << k : 16'h0000);
        end
        soft_reset = 1'b1;
        @(negedge clk_sys);
        soft_reset = 1'b0;
        smi_enable = 1'b1;
        get(LDDR_IDX_IRQ_SEL, 8'h06);
        get(LDDR_IDX_DMA_SEL, 8'h02);
        // relocation is bytewise; an odd low byte must be ignored
        set(LDDR_IDX_RELOC_HI, 8'h01);
        cfg = 16'h014e;
        chk(cfg_base_q, 16'h014e);
        set(LDDR_IDX_RELOC_LO, 8'h2f);
        chk(cfg_base_q, 16'h014e);
        get(LDDR_IDX_IRQ_SEL, 8'h06);
        i_host.rd(16'h114f, d, ok);
        chk({7'h00, ok, d}, 16'h0106);
        set(LDDR_IDX_OSC, 8'h40);
        i_host.wr(cfg, LDDR_IDX_IRQ_SEL);
        i_host.rd(16'h114f, d, ok);
        chk(16'(ok), 16'h0000);
        end_sim();
    end
endmodule // testbench
`default_nettype wire
